// >>> hw/hsw_defines.svh
// Register map, field positions, reset values and timing constants of the hot-swap register bank.
// How it works
// (R01) Latch high-rail power-good loss in bit 4.
// (R02) Latch high-rail fault-timer expiry in bit 5.
// (R03) Latch low-rail power-good loss in bit 6.
// (R04) Latch low-rail fault-timer expiry in bit 7.
// (R05) Channel flags read-only, clear on read.
// (R06) Overcurrent flags read-only, clear on read.
// (R07) Latch high-rail current-limit entry in bit 4.
// (R08) Latch high-rail fast-trip exceedance in bit 5.
// (R09) Latch low-rail current-limit entry in bit 6.
// (R10) Latch low-rail fast-trip exceedance in bit 7.
// (R11) Gate status bit 3 shows live ORing drive.
// (R12) Gate status bits 4, 5, 7 live, active low.
// (R13) Limit trim field resets to all ones.
// (R14) Power-good threshold select resets to 11B.
// (R15) Bit 6 selects positive ORing turn-off threshold.
// (R16) Clearing bit 7 forces ORing gate low.
// (R17) Fault time is code times 0.5 ms.
// (R18) Master enable low pulls both gates low.
// (R19) Interlock waits for output below bleed threshold.
// (R20) Clearing bit 7 disconnects bleed resistor.
// (R21) Host programs shortest safe fault time.
// (R22) Event during clearing read stays set.
`ifndef HSW_DEFINES_SVH
`define HSW_DEFINES_SVH

`define HSW_ADDR_LIMIT_CFG 8'h03
`define HSW_ADDR_TIMING_EN 8'h04
`define HSW_ADDR_CHAN_FLAGS 8'h07
`define HSW_ADDR_OC_FLAGS 8'h08
`define HSW_ADDR_GATE_STAT 8'h09

`define HSW_LIMIT_CFG_RST 8'hbf
`define HSW_TIMING_EN_RST 8'h01

`define HSW_BIT_ORING_POS 6
`define HSW_BIT_ORING_ALLOW 7
`define HSW_BIT_MASTER_EN 5
`define HSW_BIT_INTERLOCK 6
`define HSW_BIT_BLEED 7
`define HSW_BIT_ORING_STATE 3
`define HSW_BIT_PASS_N 4
`define HSW_BIT_FWD_N 5
`define HSW_BIT_GATE_N 7
`define HSW_TRIM_MSB 3
`define HSW_TRIM_LSB 0
`define HSW_PG_SEL_MSB 5
`define HSW_PG_SEL_LSB 4
`define HSW_FT_MSB 4
`define HSW_FT_LSB 0

`define HSW_FAULT_UNIT_US 500
`define HSW_CLK_MHZ 20

`endif

// >>> hw/hsw_pkg.sv
// Types shared by the hot-swap register bank.
package hsw_pkg;

    // Comparator and status levels coming from the analog core.
    typedef struct packed {
        logic hi_pg_above;
        logic hi_in_limit;
        logic hi_fast_trip;
        logic hi_below_bleed;
        logic hi_oring_forward;
        logic hi_pass_enhanced_n;
        logic lo_pg_above;
        logic lo_fault_expired;
        logic lo_in_limit;
        logic lo_fast_trip;
        logic lo_forward_n;
        logic lo_gate_on_n;
    } hsw_sense_t;

    typedef enum logic [1:0] {
        HSW_OFF = 2'b00,
        HSW_WAIT_BLEED = 2'b01,
        HSW_ON = 2'b10,
        HSW_FAULTED = 2'b11
    } hsw_state_t;

endpackage

// >>> hw/hsw_regs.sv
// Register bank and high-rail channel control of the dual-rail hot-swap controller.
`timescale 1ns/10ps
`include "hsw_defines.svh"
`default_nettype none

module hsw_regs #(
    parameter int FAULT_UNIT_CYC = `HSW_FAULT_UNIT_US * `HSW_CLK_MHZ
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port from the serial front end.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog comparator levels.
    input wire hsw_pkg::hsw_sense_t sense,
    // Controls to the analog core.
    output logic pass_gate_on,
    output logic oring_gate_pin,
    output logic hi_rail_bleed_connect,
    output logic [3:0] hi_rail_limit_trim,
    output logic [1:0] hi_rail_pg_threshold_sel,
    output logic hi_rail_oring_threshold_pos
);

    localparam int SW = $bits(hsw_pkg::hsw_sense_t);

    // Reset images of the configuration registers; the mirrored controls start from these.
    localparam logic [7:0] LIMIT_RST = `HSW_LIMIT_CFG_RST;
    localparam logic [7:0] TIMING_RST = `HSW_TIMING_EN_RST;

    // Input synchronisers: a change counts once stages two and three agree.
    // The filtered level and its copy one edge older feed the edge detectors below.
    logic [SW-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d, prev_q;
    hsw_pkg::hsw_sense_t f, p;

    // One synchroniser and filter per comparator line.
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_comb begin
                filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : filt_q[gi];
            end
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    filt_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= sense[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    filt_q[gi] <= filt_d[gi];
                    prev_q[gi] <= filt_q[gi];
                end
            end
        end
    endgenerate

    // Named views of the filtered and delayed levels.
    assign f = hsw_pkg::hsw_sense_t'(filt_q);
    assign p = hsw_pkg::hsw_sense_t'(prev_q);

    // Configuration registers.
    logic [7:0] limit_cfg_q, limit_cfg_d, timing_q, timing_d;

    always_comb begin
        limit_cfg_d = limit_cfg_q;
        timing_d = timing_q;
        // Writes to the flag and status addresses fall through and are ignored.
        if (reg_wr) begin
            if (reg_addr == `HSW_ADDR_LIMIT_CFG) begin
                limit_cfg_d = reg_wdata;
            end else if (reg_addr == `HSW_ADDR_TIMING_EN) begin
                timing_d = reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // (R13) Limit trim reset.
            // (R14) Threshold select reset.
            limit_cfg_q <= LIMIT_RST;
            timing_q <= TIMING_RST;
        end else begin
            limit_cfg_q <= limit_cfg_d;
            timing_q <= timing_d;
        end
    end

    logic master_en, interlock, oring_allow;
    logic [4:0] fault_code;
    assign master_en = timing_q[`HSW_BIT_MASTER_EN];
    assign interlock = timing_q[`HSW_BIT_INTERLOCK];
    assign oring_allow = limit_cfg_q[`HSW_BIT_ORING_ALLOW];
    assign fault_code = timing_q[`HSW_FT_MSB:`HSW_FT_LSB];

    // Fault timer: counts half-millisecond units while in current limit.
    // Leaving current limit restarts it, so only an unbroken stretch in limit ends in a fault.
    logic [15:0] unit_cnt_q, unit_cnt_d;
    logic [4:0] units_q, units_d;
    logic fault_expired_q, fault_expired_d;
    hsw_pkg::hsw_state_t state_q, state_d;

    always_comb begin
        unit_cnt_d = unit_cnt_q;
        units_d = units_q;
        fault_expired_d = 1'b0;
        if (state_q != hsw_pkg::HSW_ON || !f.hi_in_limit) begin
            unit_cnt_d = 16'h0000;
            units_d = 5'h00;
        end else if (unit_cnt_q == 16'(FAULT_UNIT_CYC - 1)) begin
            unit_cnt_d = 16'h0000;
            units_d = units_q + 5'h01;
            // The expiry pulse lasts one cycle; the state machine and the flag both catch it.
            // (R17) Code times 0.5 ms; a zero code acts as one unit.
            if (units_d >= fault_code || fault_code == 5'h00) begin
                fault_expired_d = 1'b1;
                units_d = 5'h00;
            end
        end else begin
            unit_cnt_d = unit_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_cnt_q <= 16'h0000;
            units_q <= 5'h00;
            fault_expired_q <= 1'b0;
        end else begin
            unit_cnt_q <= unit_cnt_d;
            units_q <= units_d;
            fault_expired_q <= fault_expired_d;
        end
    end

    // High-rail channel sequencing.
    // The gate outputs are registered from the next state, so they switch with it.
    logic pass_d, oring_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            hsw_pkg::HSW_OFF: begin
                // With the interlock set, an enable waits for the output to bleed down.
                // (R19) Bleed-down interlock.
                if (master_en) begin
                    state_d = (interlock && !f.hi_below_bleed) ? hsw_pkg::HSW_WAIT_BLEED
                                                               : hsw_pkg::HSW_ON;
                end
            end
            hsw_pkg::HSW_WAIT_BLEED: begin
                // Dropping the enable while waiting abandons the turn-on.
                if (!master_en) begin
                    state_d = hsw_pkg::HSW_OFF;
                end else if (f.hi_below_bleed) begin
                    state_d = hsw_pkg::HSW_ON;
                end
            end
            hsw_pkg::HSW_ON: begin
                // Clearing the enable or a timer expiry turns the rail off.
                if (!master_en) begin
                    state_d = hsw_pkg::HSW_OFF;
                end else if (fault_expired_q) begin
                    state_d = hsw_pkg::HSW_FAULTED;
                end
            end
            default: begin
                // A timed-out rail stays off until the host clears the enable.
                if (!master_en) begin
                    state_d = hsw_pkg::HSW_OFF;
                end
            end
        endcase
        // (R18) Disabled rail pulls both gates low.
        pass_d = (state_d == hsw_pkg::HSW_ON) && master_en;
        // The ORing gate follows the forward comparator only while the pass gate is on.
        // (R16) ORing gate forced low.
        oring_d = pass_d && oring_allow && f.hi_oring_forward;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hsw_pkg::HSW_OFF;
            pass_gate_on <= 1'b0;
            oring_gate_pin <= 1'b0;
        end else begin
            state_q <= state_d;
            pass_gate_on <= pass_d;
            oring_gate_pin <= oring_d;
        end
    end

    // Control outputs mirror the configuration fields.
    // They take the next register value, so they change on the same edge as the register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_rail_limit_trim <= LIMIT_RST[`HSW_TRIM_MSB:`HSW_TRIM_LSB];
            hi_rail_pg_threshold_sel <= LIMIT_RST[`HSW_PG_SEL_MSB:`HSW_PG_SEL_LSB];
            hi_rail_oring_threshold_pos <= LIMIT_RST[`HSW_BIT_ORING_POS];
            hi_rail_bleed_connect <= TIMING_RST[`HSW_BIT_BLEED];
        end else begin
            hi_rail_limit_trim <= limit_cfg_d[`HSW_TRIM_MSB:`HSW_TRIM_LSB];
            hi_rail_pg_threshold_sel <= limit_cfg_d[`HSW_PG_SEL_MSB:`HSW_PG_SEL_LSB];
            // (R15) Positive ORing threshold.
            hi_rail_oring_threshold_pos <= limit_cfg_d[`HSW_BIT_ORING_POS];
            // (R20) Bleed resistor connect.
            hi_rail_bleed_connect <= timing_d[`HSW_BIT_BLEED];
        end
    end

    // Latched flags, cleared on read; a new event wins over the clear.
    // Fast-trip flags follow the level, so they stay set for as long as the trip lasts.
    logic [3:0] chan_flags_q, chan_flags_d, oc_flags_q, oc_flags_d;
    logic [3:0] chan_ev, oc_ev;
    logic rd_chan, rd_oc;

    always_comb begin
        // (R01) High-rail power-good lost.
        chan_ev[0] = p.hi_pg_above && !f.hi_pg_above;
        // (R02) High-rail timer expired.
        chan_ev[1] = fault_expired_q;
        // (R03) Low-rail power-good lost.
        chan_ev[2] = p.lo_pg_above && !f.lo_pg_above;
        // (R04) Low-rail timer expired.
        chan_ev[3] = f.lo_fault_expired && !p.lo_fault_expired;
        // (R07) High-rail limit entry.
        oc_ev[0] = f.hi_in_limit && !p.hi_in_limit;
        // (R08) High-rail fast trip.
        oc_ev[1] = f.hi_fast_trip;
        // (R09) Low-rail limit entry.
        oc_ev[2] = f.lo_in_limit && !p.lo_in_limit;
        // (R10) Low-rail fast trip.
        oc_ev[3] = f.lo_fast_trip;
        // A read at a flag address clears it on the same edge that captures it.
        rd_chan = reg_rd && (reg_addr == `HSW_ADDR_CHAN_FLAGS);
        rd_oc = reg_rd && (reg_addr == `HSW_ADDR_OC_FLAGS);
        // (R05) Clear channel flags on read.
        // (R22) Event beats clear.
        chan_flags_d = (rd_chan ? 4'h0 : chan_flags_q) | chan_ev;
        // (R06) Clear overcurrent flags on read.
        oc_flags_d = (rd_oc ? 4'h0 : oc_flags_q) | oc_ev;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_flags_q <= 4'h0;
            oc_flags_q <= 4'h0;
        end else begin
            chan_flags_q <= chan_flags_d;
            oc_flags_q <= oc_flags_d;
        end
    end

    // Read data, captured on the read strobe.
    // It holds between reads, so a slow front end may shift it out at its own pace.
    logic [7:0] rdata_d, gate_stat;

    always_comb begin
        // Spare status bits read as zero.
        gate_stat = 8'h00;
        // (R11) Live ORing drive state.
        gate_stat[`HSW_BIT_ORING_STATE] = oring_gate_pin;
        // (R12) Live active-low status.
        gate_stat[`HSW_BIT_PASS_N] = f.hi_pass_enhanced_n;
        gate_stat[`HSW_BIT_FWD_N] = f.lo_forward_n;
        gate_stat[`HSW_BIT_GATE_N] = f.lo_gate_on_n;
        rdata_d = reg_rdata;
        if (reg_rd) begin
            if (reg_addr == `HSW_ADDR_LIMIT_CFG) begin
                rdata_d = limit_cfg_q;
            end else if (reg_addr == `HSW_ADDR_TIMING_EN) begin
                rdata_d = timing_q;
            end else if (reg_addr == `HSW_ADDR_CHAN_FLAGS) begin
                rdata_d = {chan_flags_q, 4'h0};
            end else if (reg_addr == `HSW_ADDR_OC_FLAGS) begin
                rdata_d = {oc_flags_q, 4'h0};
            end else if (reg_addr == `HSW_ADDR_GATE_STAT) begin
                rdata_d = gate_stat;
            end else begin
                // Unmapped addresses read as zero.
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// >>> verification/hsw_host_model.sv
// Host-side model issuing one-cycle write and read strobes on the register port.
`timescale 1ns/10ps
`default_nettype none
module hsw_host_model (
    // Clock.
    input wire logic sys_clk,
    // Register port.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle address and data show the inverse so stale values are never trusted.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> verification/hsw_regs_monitor.sv
// Concurrent checks on the ports of the hot-swap register bank.
`timescale 1ns/10ps
`default_nettype none
module hsw_regs_monitor (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Sense levels and controls.
    input wire hsw_pkg::hsw_sense_t sense,
    input wire logic pass_gate_on,
    input wire logic oring_gate_pin,
    input wire logic hi_rail_bleed_connect,
    input wire logic [3:0] hi_rail_limit_trim,
    input wire logic [1:0] hi_rail_pg_threshold_sel,
    input wire logic hi_rail_oring_threshold_pos
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] wd_q;
    wire logic cfg_wr = reg_wr && reg_addr == 8'h03;
    wire logic en_wr = reg_wr && reg_addr == 8'h04;
    always_ff @(posedge sys_clk) wd_q <= reg_wdata;
    trim_mirror_a: assert property (cfg_wr |=> hi_rail_limit_trim == wd_q[3:0])
        else $error("limit trim does not follow write");
    pg_sel_mirror_a: assert property (cfg_wr |=> hi_rail_pg_threshold_sel == wd_q[5:4])
        else $error("threshold select does not follow write");
    oring_pos_mirror_a: assert property (cfg_wr |=> hi_rail_oring_threshold_pos == wd_q[6])
        else $error("oring threshold bit does not follow write");
    // Gate controls follow the stored enable bits, so they drop one edge after the write.
    oring_forced_low_a: assert property (cfg_wr && !reg_wdata[7] |-> ##2 !oring_gate_pin)
        else $error("oring gate not forced low");
    bleed_mirror_a: assert property (en_wr |=> hi_rail_bleed_connect == wd_q[7])
        else $error("bleed control does not follow write");
    enable_off_a: assert property (en_wr && !reg_wdata[5] |->
        ##2 !pass_gate_on && !oring_gate_pin) else $error("gates not low after disable");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    spare_zero_a: assert property (reg_rd && reg_addr inside {8'h07, 8'h08} |=>
        reg_rdata[3:0] == 4'h0) else $error("unused flag bits not zero");
endmodule
`default_nettype wire

// >>> verification/hsw_regs_tb_top.sv
// Self-checking bench for the hot-swap register bank.
`timescale 1ns/10ps
`default_nettype none
module hot_swap_status_config_regs_tb_top;
    logic sys_clk, rst_n, reg_wr, reg_rd, pass_gate_on, oring_gate_pin, bleed, oring_pos;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [3:0] trim;
    logic [1:0] pg_sel;
    hsw_pkg::hsw_sense_t sense;
    int fails, check_count;
    hsw_regs #(.FAULT_UNIT_CYC(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sense(sense), .pass_gate_on(pass_gate_on),
        .oring_gate_pin(oring_gate_pin), .hi_rail_bleed_connect(bleed),
        .hi_rail_limit_trim(trim), .hi_rail_pg_threshold_sel(pg_sel),
        .hi_rail_oring_threshold_pos(oring_pos));
    hsw_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
        host.rd(a, v);
        chk(n, e, v);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_regs;
        chk("cfg_rst", 8'h3f, {1'b0, oring_pos, pg_sel, trim});
        chk("bleed_rst", 8'h00, {7'h0, bleed});
        rdc(8'h03, 8'hbf, "limit_cfg");
        rdc(8'h04, 8'h01, "timing_en");
        rdc(8'h07, 8'h00, "chan_flags");
        rdc(8'h08, 8'h00, "oc_flags");
        rdc(8'h0a, 8'h00, "unmapped");
        host.wr(8'h07, 8'hff);
        rdc(8'h07, 8'h00, "chan_ro");
        host.wr(8'h03, 8'h5a);
        chk("cfg_out", 8'h5a, {1'b0, oring_pos, pg_sel, trim});
        host.wr(8'h04, 8'h81);
        chk("bleed_on", 8'h01, {7'h0, bleed});
        host.wr(8'h04, 8'h01);
        chk("bleed_off", 8'h00, {7'h0, bleed});
        host.wr(8'h03, 8'hbf);
    endtask
    task automatic t_flags;
        sense.hi_pg_above = 1'b1;
        sense.lo_pg_above = 1'b1;
        wt(8);
        sense = '0;
        sense.lo_fault_expired = 1'b1;
        {sense.hi_in_limit, sense.lo_in_limit, sense.hi_fast_trip, sense.lo_fast_trip} = 4'hf;
        wt(8);
        sense = '0;
        wt(8);
        rdc(8'h07, 8'hd0, "chan_set");
        rdc(8'h07, 8'h00, "chan_clr");
        rdc(8'h08, 8'hf0, "oc_set");
        rdc(8'h08, 8'h00, "oc_clr");
        sense.hi_fast_trip = 1'b1;
        wt(8);
        rdc(8'h08, 8'h20, "trip_in_read");
        sense = '0;
        wt(8);
        rdc(8'h08, 8'h20, "trip_kept");
        rdc(8'h08, 8'h00, "trip_clr");
    endtask
    task automatic t_gate;
        sense.lo_forward_n = 1'b1;
        sense.hi_oring_forward = 1'b1;
        wt(8);
        rdc(8'h09, 8'h20, "gate_idle");
        host.wr(8'h04, 8'h21);
        wt(2);
        chk("gates_on", 8'h03, {6'h0, pass_gate_on, oring_gate_pin});
        rdc(8'h09, 8'h28, "gate_on");
        host.wr(8'h03, 8'h3f);
        wt(1);
        chk("oring_off", 8'h02, {6'h0, pass_gate_on, oring_gate_pin});
        host.wr(8'h03, 8'hbf);
        sense.hi_in_limit = 1'b1;
        wt(20);
        chk("faulted", 8'h00, {6'h0, pass_gate_on, oring_gate_pin});
        sense.hi_in_limit = 1'b0;
        rdc(8'h07, 8'h20, "timeout");
        rdc(8'h08, 8'h10, "limit");
        host.wr(8'h04, 8'h01);
    endtask
    task automatic t_lock;
        host.wr(8'h04, 8'h61);
        wt(8);
        chk("lock_wait", 8'h00, {7'h0, pass_gate_on});
        sense.hi_below_bleed = 1'b1;
        wt(8);
        chk("lock_go", 8'h01, {7'h0, pass_gate_on});
        host.wr(8'h04, 8'h41);
        wt(1);
        chk("disable", 8'h00, {7'h0, pass_gate_on});
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        fails++;
        complete_run;
    end
    initial begin
        rst_n = 1'b0;
        sense = '0;
        fails = 0;
        check_count = 0;
        wt(5);
        rst_n = 1'b1;
        wt(4);
        t_regs;
        t_flags;
        t_gate;
        t_lock;
        complete_run;
    end
endmodule
bind hsw_regs hsw_regs_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sense(sense), .pass_gate_on(pass_gate_on), .oring_gate_pin(oring_gate_pin),
    .hi_rail_bleed_connect(hi_rail_bleed_connect), .hi_rail_limit_trim(hi_rail_limit_trim),
    .hi_rail_pg_threshold_sel(hi_rail_pg_threshold_sel),
    .hi_rail_oring_threshold_pos(hi_rail_oring_threshold_pos));
`default_nettype wire
